// ---- rtl/acs_pkg.sv ----
package acs_pkg;
   localparam int CLK_PERIOD_NS  = 40;
   localparam int INSTR_TIME_NS  = 160;
   localparam int SETTLE_TIME_NS = 120;
   localparam int INSTR_CYCLES   = (INSTR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_CYCLES  = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int RES_BITS = 10;
   localparam int IDX_W    = 4;
   localparam int CNT_W    = 4;
   localparam int ADDR_W   = 5;
   localparam int DATA_W   = 32;
   localparam int LOW_W    = 8;
   localparam int HIGH_W   = RES_BITS - LOW_W;

   localparam logic [ADDR_W-1:0] OFF_CTRL   = 5'h00;
   localparam logic [ADDR_W-1:0] OFF_RESH   = 5'h04;
   localparam logic [ADDR_W-1:0] OFF_RESL   = 5'h08;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h0C;
   localparam logic [ADDR_W-1:0] OFF_MASK   = 5'h10;

   localparam int CTRL_EN_BIT  = 0;
   localparam int CTRL_GO_BIT  = 1;
   localparam int CTRL_CLK_LSB = 2;
   localparam int CLK_SEL_W    = 2;
   localparam logic [CLK_SEL_W-1:0] CLK_SEL_RC    = 2'h3;
   localparam logic [CLK_SEL_W-1:0] CLK_SEL_RESET = 2'h0;

   localparam int IRQ_W         = 2;
   localparam int IRQ_DONE_BIT  = 0;
   localparam int IRQ_ABORT_BIT = 1;

   typedef enum logic [3:0] {
      ACS_ENG_IDLE  = 4'h1,
      ACS_ENG_WAIT  = 4'h2,
      ACS_ENG_TRIAL = 4'h4,
      ACS_ENG_SPARE = 4'h8
   } acs_eng_t;
endpackage : acs_pkg

// ---- rtl/acs_conv_if.sv ----
`timescale 1ns/1ps
interface acs_conv_if #(parameter int RES_BITS = acs_pkg::RES_BITS);
   logic                start;
   logic                abort;
   logic                extraDelay;
   logic                cmpBit;
   logic                done;
   logic                aborted;
   logic                sampleHold;
   logic [RES_BITS-1:0] result;
   logic [RES_BITS-1:0] dacCode;

   modport ctrl   (output start, abort, extraDelay, cmpBit,
                   input  done, aborted, sampleHold, result, dacCode);
   modport engine (input  start, abort, extraDelay, cmpBit,
                   output done, aborted, sampleHold, result, dacCode);
endinterface : acs_conv_if

// ---- rtl/acs_sar_engine.sv ----
`timescale 1ns/1ps
module acs_sar_engine #(
   parameter int RES_BITS = acs_pkg::RES_BITS
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   acs_conv_if.engine conv
);
   typedef struct packed {
      acs_pkg::acs_eng_t              state;
      logic [acs_pkg::IDX_W-1:0]      idx;
      logic [acs_pkg::CNT_W-1:0]      cnt;
      logic [RES_BITS-1:0]            code;
      logic [RES_BITS-1:0]            result;
      logic                           lastBit;
      logic                           resolved;
      logic                           done;
      logic                           aborted;
      logic                           hold;
   } acs_eng_state_t;

   localparam logic [acs_pkg::IDX_W-1:0] MSB_IDX    = acs_pkg::IDX_W'(RES_BITS - 1);
   localparam logic [acs_pkg::CNT_W-1:0] INSTR_LOAD = acs_pkg::CNT_W'(acs_pkg::INSTR_CYCLES - 1);
   localparam logic [acs_pkg::CNT_W-1:0] SETTLE_LOAD =
      acs_pkg::CNT_W'(acs_pkg::SETTLE_CYCLES - 1);
   localparam acs_eng_state_t RESET_STATE = '{state: acs_pkg::ACS_ENG_IDLE, default: '0};

   acs_eng_state_t s_reg;
   acs_eng_state_t s_next;
   logic [RES_BITS-1:0] partial;

   // Unresolved bits copy the last resolved one
   always_comb begin
      for (int i = 0; i < RES_BITS; i++) begin
         if (s_reg.state == acs_pkg::ACS_ENG_WAIT || i <= int'(s_reg.idx)) begin
            partial[i] = s_reg.resolved ? s_reg.lastBit : 1'b0;   // see RQ6
         end else begin
            partial[i] = s_reg.code[i];
         end
      end
   end

   always_comb begin
      s_next = s_reg;
      s_next.done = 1'b0;
      s_next.aborted = 1'b0;
      case (s_reg.state)
         acs_pkg::ACS_ENG_IDLE: begin
            if (conv.start) begin
               s_next.code = '0;
               s_next.resolved = 1'b0;
               s_next.lastBit = 1'b0;
               s_next.idx = MSB_IDX;
               if (conv.extraDelay) begin
                  s_next.state = acs_pkg::ACS_ENG_WAIT;   // see RQ9
                  s_next.cnt = INSTR_LOAD;
               end else begin
                  s_next.state = acs_pkg::ACS_ENG_TRIAL;
                  s_next.code[MSB_IDX] = 1'b1;
                  s_next.cnt = SETTLE_LOAD;
               end
            end
         end
         acs_pkg::ACS_ENG_WAIT, acs_pkg::ACS_ENG_TRIAL: begin
            if (conv.abort) begin
               s_next.state = acs_pkg::ACS_ENG_IDLE;
               s_next.result = partial;   // see RQ5
               s_next.aborted = 1'b1;
            end else if (s_reg.cnt != '0) begin
               s_next.cnt = s_reg.cnt - 4'h1;
            end else if (s_reg.state == acs_pkg::ACS_ENG_WAIT) begin
               s_next.state = acs_pkg::ACS_ENG_TRIAL;
               s_next.code[MSB_IDX] = 1'b1;
               s_next.cnt = SETTLE_LOAD;
            end else begin
               s_next.code[s_reg.idx] = conv.cmpBit;
               s_next.lastBit = conv.cmpBit;
               s_next.resolved = 1'b1;
               if (s_reg.idx == '0) begin
                  s_next.state = acs_pkg::ACS_ENG_IDLE;
                  s_next.result = s_next.code;
                  s_next.done = 1'b1;
               end else begin
                  s_next.idx = s_reg.idx - 4'h1;
                  s_next.code[s_reg.idx - 4'h1] = 1'b1;
                  s_next.cnt = SETTLE_LOAD;
               end
            end
         end
         default: s_next = RESET_STATE;
      endcase
      s_next.hold = s_next.state != acs_pkg::ACS_ENG_IDLE;
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_reg <= RESET_STATE;
      end else begin
         s_reg <= s_next;
      end
   end

   assign conv.done       = s_reg.done;
   assign conv.aborted    = s_reg.aborted;
   assign conv.result     = s_reg.result;
   assign conv.dacCode    = s_reg.code;
   assign conv.sampleHold = s_reg.hold;

   AST_RC_START_DELAY: assert property (@(posedge core_clk) disable iff (sys_rst || conv.abort) // see RQ9
      s_reg.state == acs_pkg::ACS_ENG_IDLE && conv.start && conv.extraDelay
      |=> (s_reg.state == acs_pkg::ACS_ENG_WAIT && !conv.abort)[*4]
      ##1 s_reg.state == acs_pkg::ACS_ENG_TRIAL)
      else $error("Dedicated clock start not delayed by one instruction");

   AST_ABORT_FILL: assert property (@(posedge core_clk) disable iff (sys_rst) // see RQ6
      s_reg.state == acs_pkg::ACS_ENG_TRIAL && conv.abort && s_reg.resolved
      |=> s_reg.aborted && s_reg.result[0] == $past(s_reg.lastBit))
      else $error("Early result not filled with last resolved bit");
endmodule : acs_sar_engine

// ---- rtl/acs_sequencer.sv ----
`timescale 1ns/1ps
// Function
// RQ1: Converter runs only while enable bit set
// RQ2: Writing go bit as one starts conversion
// RQ3: Software enables before setting go
// RQ4: Completion clears go, flags, loads result
// RQ5: Clearing go early stores partial result
// RQ6: Unresolved bits copy last resolved bit
// RQ7: Reset restores registers, aborts conversion
// RQ8: Sleep conversions only with dedicated clock
// RQ9: Dedicated clock delays start one instruction
// RQ10: Enabled interrupt completion wakes sleeping device
// RQ11: Disabled interrupt: power off, enable kept
// RQ12: Sleep on other clock aborts, enable kept
// RQ13: Trigger sets go and clears timer one
// RQ14: Software ensures timing under hardware trigger
// RQ15: Done flag stays until software clears
module acs_sequencer #(
   parameter int RES_BITS = acs_pkg::RES_BITS
) (
   input  wire logic                        core_clk,
   input  wire logic                        sys_rst,
   input  wire logic [acs_pkg::ADDR_W-1:0]  avs_address,
   input  wire logic                        avs_read,
   input  wire logic                        avs_write,
   input  wire logic [acs_pkg::DATA_W-1:0]  avs_writedata,
   output      logic [acs_pkg::DATA_W-1:0]  avs_readdata,
   output      logic                        avs_waitrequest,
   input  wire logic                        sleepReq,
   input  wire logic                        specialTrigger,
   input  wire logic                        comparatorOut,
   output      logic [RES_BITS-1:0]         dacCode,
   output      logic                        sampleHold,
   output      logic                        converterOn,
   output      logic                        timerOneClear,
   output      logic                        wakeReq,
   output      logic                        irq
);
   typedef struct packed {
      logic                            en;
      logic                            go;
      logic [acs_pkg::CLK_SEL_W-1:0]   clkSel;
      logic                            powered;
      logic                            on;
      logic [acs_pkg::IRQ_W-1:0]       status;
      logic [acs_pkg::IRQ_W-1:0]       mask;
      logic [RES_BITS-1:0]             result;
      logic                            waitReq;
      logic [acs_pkg::DATA_W-1:0]      readData;
      logic                            irq;
      logic                            timerClr;
      logic                            wake;
      logic                            start;
      logic                            abort;
      logic                            sleepS1;
      logic                            sleepS2;
      logic                            cmpS1;
      logic                            cmpS2;
   } acs_top_state_t;

   localparam acs_top_state_t RESET_STATE = '{waitReq: 1'b1, default: '0};

   acs_top_state_t s_reg;
   acs_top_state_t s_next;
   acs_conv_if #(.RES_BITS(RES_BITS)) conv ();

   logic                       take;
   logic                       isRc;
   logic                       ctrlWr;
   logic                       statusRd;
   logic                       goWr;
   logic                       enWr;
   logic [acs_pkg::DATA_W-1:0] rdMux;

   assign take     = (avs_read || avs_write) && !s_reg.waitReq;
   assign isRc     = s_reg.clkSel == acs_pkg::CLK_SEL_RC;   // see RQ8
   assign ctrlWr   = take && avs_write && avs_address == acs_pkg::OFF_CTRL;
   assign statusRd = take && avs_read && avs_address == acs_pkg::OFF_STATUS;
   assign goWr     = avs_writedata[acs_pkg::CTRL_GO_BIT];
   assign enWr     = avs_writedata[acs_pkg::CTRL_EN_BIT];

   always_comb begin
      rdMux = '0;
      case (avs_address)
         acs_pkg::OFF_CTRL: begin
            rdMux[acs_pkg::CTRL_EN_BIT] = s_reg.en;
            rdMux[acs_pkg::CTRL_GO_BIT] = s_reg.go;
            rdMux[acs_pkg::CTRL_CLK_LSB +: acs_pkg::CLK_SEL_W] = s_reg.clkSel;
         end
         acs_pkg::OFF_RESH:   rdMux[acs_pkg::HIGH_W-1:0] = s_reg.result[RES_BITS-1:acs_pkg::LOW_W];
         acs_pkg::OFF_RESL:   rdMux[acs_pkg::LOW_W-1:0] = s_reg.result[acs_pkg::LOW_W-1:0];
         acs_pkg::OFF_STATUS: rdMux[acs_pkg::IRQ_W-1:0] = s_reg.status;
         acs_pkg::OFF_MASK:   rdMux[acs_pkg::IRQ_W-1:0] = s_reg.mask;
         default:             rdMux = '0;
      endcase
   end

   always_comb begin
      s_next = s_reg;
      s_next.sleepS1 = sleepReq;
      s_next.sleepS2 = s_reg.sleepS1;
      s_next.cmpS1 = comparatorOut;
      s_next.cmpS2 = s_reg.cmpS1;
      s_next.start = 1'b0;
      s_next.abort = 1'b0;
      s_next.timerClr = 1'b0;
      s_next.wake = 1'b0;

      // One wait cycle, then the answer stands for the taking edge
      s_next.waitReq = 1'b1;
      if ((avs_read || avs_write) && s_reg.waitReq) begin
         s_next.waitReq = 1'b0;
         s_next.readData = rdMux;
      end

      if (statusRd) begin
         s_next.status = '0;   // see RQ15
      end
      if (take && avs_write && avs_address == acs_pkg::OFF_MASK) begin
         s_next.mask = avs_writedata[acs_pkg::IRQ_W-1:0];
      end
      if (ctrlWr) begin
         s_next.en = enWr;   // see RQ1
         s_next.clkSel = avs_writedata[acs_pkg::CTRL_CLK_LSB +: acs_pkg::CLK_SEL_W];
         if (enWr) begin
            s_next.powered = 1'b1;
         end
         if (!s_reg.go && goWr && enWr && s_reg.on) begin
            s_next.go = 1'b1;   // see RQ2
            s_next.start = 1'b1;
         end else if (s_reg.go && (!goWr || !enWr)) begin
            s_next.go = 1'b0;   // see RQ5
            s_next.abort = 1'b1;
         end
      end

      if (specialTrigger) begin
         s_next.timerClr = 1'b1;   // see RQ13
         if (s_reg.on && s_next.en && !s_reg.go && !s_next.go) begin
            s_next.go = 1'b1;
            s_next.start = 1'b1;
         end
      end

      // Other clock sources stop while the core sleeps
      if (s_reg.sleepS2 && !isRc && s_reg.powered) begin
         s_next.powered = 1'b0;   // see RQ12
         // Also cancels a start requested in this very cycle
         if (s_next.go) begin
            s_next.go = 1'b0;
            s_next.start = 1'b0;
            s_next.abort = s_reg.go;
         end
      end

      if (conv.done) begin
         s_next.go = 1'b0;   // see RQ4
         s_next.result = conv.result;
         s_next.status[acs_pkg::IRQ_DONE_BIT] = 1'b1;
         if (s_reg.sleepS2 && isRc) begin
            if (s_reg.mask[acs_pkg::IRQ_DONE_BIT]) begin
               s_next.wake = 1'b1;   // see RQ10
            end else begin
               s_next.powered = 1'b0;   // see RQ11
            end
         end
      end
      if (conv.aborted) begin
         s_next.result = conv.result;   // see RQ5
         s_next.status[acs_pkg::IRQ_ABORT_BIT] = 1'b1;
      end

      s_next.on = s_next.en && s_next.powered;
      s_next.irq = |(s_next.status & s_next.mask);
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_reg <= RESET_STATE;   // see RQ7
      end else begin
         s_reg <= s_next;
      end
   end

   assign conv.start      = s_reg.start;
   assign conv.abort      = s_reg.abort;
   assign conv.extraDelay = isRc;   // see RQ9
   assign conv.cmpBit     = s_reg.cmpS2;

   acs_sar_engine #(.RES_BITS(RES_BITS)) u_engine (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .conv     (conv)
   );

   assign avs_readdata    = s_reg.readData;
   assign avs_waitrequest = s_reg.waitReq;
   assign dacCode         = conv.dacCode;
   assign sampleHold      = conv.sampleHold;
   assign converterOn     = s_reg.on;
   assign timerOneClear   = s_reg.timerClr;
   assign wakeReq         = s_reg.wake;
   assign irq             = s_reg.irq;

   AST_START_NEEDS_ON: assert property (@(posedge core_clk) disable iff (sys_rst) // see RQ1
      s_reg.start |-> s_reg.on && s_reg.en)
      else $error("Conversion started while converter off");

   AST_GO_WRITE_STARTS: assert property (@(posedge core_clk) disable iff (sys_rst) // see RQ2
      ctrlWr && goWr && enWr && s_reg.on && !s_reg.go && !s_reg.sleepS2
      |=> s_reg.go && s_reg.start ##1 conv.sampleHold)
      else $error("Go write did not start a conversion");

   AST_DONE_LOADS: assert property (@(posedge core_clk) disable iff (sys_rst) // see RQ4
      conv.done |=> !s_reg.go && s_reg.status[acs_pkg::IRQ_DONE_BIT]
      && s_reg.result == $past(conv.result))
      else $error("Completion did not clear go and load result");

   AST_GO_CLEAR_ABORTS: assert property (@(posedge core_clk) disable iff (sys_rst) // see RQ5
      ctrlWr && s_reg.go && !goWr && !conv.done
      |=> s_reg.abort ##1 (conv.aborted || $past(conv.done)))
      else $error("Clearing go did not terminate conversion");

   AST_RESET_OFF: assert property (@(posedge core_clk) // see RQ7
      sys_rst |-> !s_reg.go && !s_reg.en && !s_reg.on && s_reg.status == '0)
      else $error("Reset left converter active");

   AST_RC_SLEEP_RUNS: assert property (@(posedge core_clk) disable iff (sys_rst) // see RQ8
      s_reg.sleepS2 && isRc && s_reg.go && !take && !conv.done && !conv.aborted
      |=> s_reg.go && !s_reg.abort)
      else $error("Dedicated clock conversion stopped by sleep");

   AST_DONE_WAKES: assert property (@(posedge core_clk) disable iff (sys_rst) // see RQ10
      conv.done && s_reg.sleepS2 && isRc && s_reg.mask[acs_pkg::IRQ_DONE_BIT] |=> wakeReq)
      else $error("Completion in sleep did not wake device");

   AST_DONE_POWERS_OFF: assert property (@(posedge core_clk) disable iff (sys_rst) // see RQ11
      conv.done && s_reg.sleepS2 && isRc && !s_reg.mask[acs_pkg::IRQ_DONE_BIT] && !take
      |=> !converterOn && s_reg.en == $past(s_reg.en))
      else $error("Converter not powered off after sleep completion");

   AST_SLEEP_ABORT: assert property (@(posedge core_clk) disable iff (sys_rst) // see RQ12
      s_reg.sleepS2 && !isRc && s_reg.go && !take |=> !s_reg.go && s_reg.abort
      && !converterOn && s_reg.en)
      else $error("Sleep on other clock did not abort");

   AST_TRIGGER: assert property (@(posedge core_clk) disable iff (sys_rst) // see RQ13
      specialTrigger && s_reg.on && !s_reg.go && !take && !s_reg.sleepS2
      |=> timerOneClear && s_reg.go)
      else $error("Trigger did not set go and clear timer");

   AST_FLAG_STICKY: assert property (@(posedge core_clk) disable iff (sys_rst) // see RQ15
      s_reg.status[acs_pkg::IRQ_DONE_BIT] && !statusRd |=> s_reg.status[acs_pkg::IRQ_DONE_BIT])
      else $error("Done flag cleared without software");

   AST_EN_GATES_GO: assert property (@(posedge core_clk) disable iff (sys_rst) // see RQ1
      !s_reg.en |-> !s_reg.on && !s_reg.go)
      else $error("Converter active with enable clear");

   AST_ABORT_LOADS: assert property (@(posedge core_clk) disable iff (sys_rst) // see RQ5
      conv.aborted |=> s_reg.status[acs_pkg::IRQ_ABORT_BIT]
      && s_reg.result == $past(conv.result))
      else $error("Early termination did not load result");

   AST_TIMER_CLEAR: assert property (@(posedge core_clk) disable iff (sys_rst) // see RQ13
      timerOneClear == $past(specialTrigger))
      else $error("Timer clear does not follow trigger");
endmodule : acs_sequencer

// ---- test/acs_analog_model.sv ----
`timescale 1ns/1ps
module acs_analog_model (
   input  wire logic [acs_pkg::RES_BITS-1:0] dacCode,
   input  wire logic                         core_clk,
   input  wire logic                         sampleHold,
   input  wire logic                         converterOn,
   input  wire logic [acs_pkg::RES_BITS-1:0] vin,
   output      logic                         comparatorOut
);
   logic [acs_pkg::RES_BITS-1:0] heldReg;

   // Track the input until the sample is held, so the code cannot move mid-conversion
   always_ff @(posedge core_clk) begin
      if (sampleHold !== 1'b1) begin
         heldReg <= vin;
      end
   end

   // Unpowered comparator reads low; trial kept while input is not below it
   assign comparatorOut = converterOn && (heldReg >= dacCode);
endmodule : acs_analog_model

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   localparam int W = acs_pkg::RES_BITS;
   typedef struct packed {
      logic [W-1:0] v;
      logic [1:0]   sel;
      logic [W-1:0] exp;
   } acs_row_t;
   localparam acs_row_t ROWS [6] = '{'{10'h000, 2'h0, 10'h000}, '{10'h3FF, 2'h0, 10'h3FF},
      '{10'h2AA, 2'h1, 10'h2AA}, '{10'h155, 2'h2, 10'h155}, '{10'h201, 2'h3, 10'h201},
      '{10'h1FE, 2'h3, 10'h1FE}};

   logic         core_clk;
   logic         sys_rst;
   logic [4:0]   avsAddress;
   logic         avsRead;
   logic         avsWrite;
   logic [31:0]  avsWritedata;
   logic [31:0]  avsReaddata;
   logic         avsWaitrequest;
   logic         sleepReq;
   logic         specialTrigger;
   logic         comparatorOut;
   logic [W-1:0] dacCode;
   logic         sampleHold;
   logic         converterOn;
   logic         timerOneClear;
   logic         wakeReq;
   logic         irq;
   logic [W-1:0] vin;
   logic [31:0]  rdata;
   int           errCount;
   int           samplesChecked;
   int           wakeCount;
   int           lat0;
   int           lat3;
   int           n;

   acs_sequencer i_acs_sequencer (
      .core_clk       (core_clk),
      .sys_rst        (sys_rst),
      .avs_address    (avsAddress),
      .avs_read       (avsRead),
      .avs_write      (avsWrite),
      .avs_writedata  (avsWritedata),
      .avs_readdata   (avsReaddata),
      .avs_waitrequest(avsWaitrequest),
      .sleepReq       (sleepReq),
      .specialTrigger (specialTrigger),
      .comparatorOut  (comparatorOut),
      .dacCode        (dacCode),
      .sampleHold     (sampleHold),
      .converterOn    (converterOn),
      .timerOneClear  (timerOneClear),
      .wakeReq        (wakeReq),
      .irq            (irq)
   );

   acs_analog_model i_acs_analog_model (
      .dacCode      (dacCode),
      .core_clk     (core_clk),
      .sampleHold   (sampleHold),
      .converterOn  (converterOn),
      .vin          (vin),
      .comparatorOut(comparatorOut)
   );

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      if (wakeReq === 1'b1) wakeCount++;
   end

   task endSim;
      if (errCount == 0 && samplesChecked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : endSim

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         errCount++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task hang;
      errCount++;
      endSim();
   endtask : hang

   task bus(input logic wr, input logic [4:0] addr, input logic [31:0] wd);
      int k;
      @(posedge core_clk);
      avsAddress   <= addr;
      avsWritedata <= wd;
      avsWrite     <= wr;
      avsRead      <= !wr;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (avsWaitrequest !== 1'b0 && k < 20);
      if (k >= 20) hang();
      rdata = avsReaddata;
      avsRead  <= 1'b0;
      avsWrite <= 1'b0;
   endtask : bus

   task rdChk(input logic [4:0] addr, input logic [31:0] exp, input string name);
      bus(1'b0, addr, 32'h0);
      check(name, rdata, exp);
   endtask : rdChk

   // Waits for irq high, a wake pulse, or power dropping
   task waitCyc(input int sel, output int c);
      c = 0;
      do begin
         @(posedge core_clk);
         c++;
      end while (!(sel == 0 ? irq === 1'b1 : sel == 1 ? wakeReq === 1'b1 : converterOn === 1'b0)
                 && c < 300);
      if (c >= 300) hang();
   endtask : waitCyc

   task waitIdle;
      int k;
      k = 0;
      do begin
         bus(1'b0, acs_pkg::OFF_CTRL, 32'h0);
         k++;
      end while (rdata[acs_pkg::CTRL_GO_BIT] !== 1'b0 && k < 40);
      if (k >= 40) hang();
   endtask : waitIdle

   task start(input logic [W-1:0] v, input logic [1:0] sel);
      vin <= v;
      bus(1'b1, acs_pkg::OFF_CTRL, {28'h0, sel, 2'b01});
      bus(1'b1, acs_pkg::OFF_CTRL, {28'h0, sel, 2'b11});
   endtask : start

   task resetChk;
      check("converterOn", {31'h0, converterOn}, 32'h0);
      check("irq", {31'h0, irq}, 32'h0);
      for (int a = 0; a <= 20; a += 4) begin
         rdChk(a[4:0], 32'h0, "register after reset");
      end
   endtask : resetChk

   initial begin
      sys_rst        = 1'b1;
      avsAddress     = 5'h00;
      avsRead        = 1'b0;
      avsWrite       = 1'b0;
      avsWritedata   = 32'h0;
      sleepReq       = 1'b0;
      specialTrigger = 1'b0;
      vin            = 10'h000;
      errCount       = 0;
      samplesChecked = 0;
      wakeCount      = 0;
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      resetChk();
      bus(1'b1, acs_pkg::OFF_CTRL, 32'h2);
      rdChk(acs_pkg::OFF_CTRL, 32'h0, "go while off");
      bus(1'b1, acs_pkg::OFF_CTRL, 32'h3);
      rdChk(acs_pkg::OFF_CTRL, 32'h1, "enable with go");
      check("converterOn", {31'h0, converterOn}, 32'h1);
      bus(1'b1, acs_pkg::OFF_RESL, 32'hFF);
      rdChk(acs_pkg::OFF_RESL, 32'h0, "result low read-only");
      bus(1'b1, acs_pkg::OFF_MASK, 32'h1);
      foreach (ROWS[i]) begin
         start(ROWS[i].v, ROWS[i].sel);
         waitCyc(0, n);
         if (ROWS[i].sel == 2'h0) lat0 = n;
         if (ROWS[i].sel == 2'h3) lat3 = n;
         rdChk(acs_pkg::OFF_CTRL, {28'h0, ROWS[i].sel, 2'b01}, "go cleared");
         rdChk(acs_pkg::OFF_RESH, {30'h0, ROWS[i].exp[9:8]}, "result high");
         rdChk(acs_pkg::OFF_RESL, {24'h0, ROWS[i].exp[7:0]}, "result low");
         rdChk(acs_pkg::OFF_STATUS, 32'h1, "status done");
         rdChk(acs_pkg::OFF_STATUS, 32'h0, "status after read");
         check("irq after read", {31'h0, irq}, 32'h0);
      end
      check("rc start delay", 32'(lat3 - lat0), 32'(acs_pkg::INSTR_CYCLES));
      // Flag survives a fresh start
      start(10'h0F0, 2'h0);
      waitCyc(0, n);
      bus(1'b1, acs_pkg::OFF_CTRL, 32'h3);
      check("irq held", {31'h0, irq}, 32'h1);
      waitIdle();
      rdChk(acs_pkg::OFF_STATUS, 32'h1, "status held");
      for (int i = 0; i < 2; i++) begin
         start(i ? 10'h200 : 10'h3FF, 2'h0);
         repeat (12) @(posedge core_clk);
         bus(1'b1, acs_pkg::OFF_CTRL, 32'h1);
         rdChk(acs_pkg::OFF_CTRL, 32'h1, "ctrl after abort");
         rdChk(acs_pkg::OFF_RESH, i ? 32'h2 : 32'h3, "partial high");
         rdChk(acs_pkg::OFF_RESL, i ? 32'h0 : 32'hFF, "partial low");
         check("irq masked abort", {31'h0, irq}, 32'h0);
         rdChk(acs_pkg::OFF_STATUS, 32'h2, "status aborted");
      end
      vin <= 10'h0A5;
      @(posedge core_clk);
      specialTrigger <= 1'b1;
      @(posedge core_clk);
      specialTrigger <= 1'b0;
      #1 check("timer clear", {31'h0, timerOneClear}, 32'h1);
      @(posedge core_clk);
      #1 check("timer clear pulse", {31'h0, timerOneClear}, 32'h0);
      check("sampleHold by trigger", {31'h0, sampleHold}, 32'h1);
      check("first trial code", {22'h0, dacCode}, 32'h200);
      rdChk(acs_pkg::OFF_CTRL, 32'h3, "go by trigger");
      waitIdle();
      rdChk(acs_pkg::OFF_RESL, 32'hA5, "trigger result");
      rdChk(acs_pkg::OFF_STATUS, 32'h1, "trigger done");
      start(10'h111, 2'h0);
      sleepReq <= 1'b1;
      waitCyc(2, n);
      check("sleep abort", 32'(n <= 6), 32'h1);
      rdChk(acs_pkg::OFF_CTRL, 32'h1, "enable kept");
      sleepReq <= 1'b0;
      repeat (3) @(posedge core_clk);
      rdChk(acs_pkg::OFF_STATUS, 32'h2, "sleep abort status");
      start(10'h2C3, 2'h3);
      sleepReq <= 1'b1;
      waitCyc(1, n);
      check("on after wake", {31'h0, converterOn}, 32'h1);
      sleepReq <= 1'b0;
      rdChk(acs_pkg::OFF_RESH, 32'h2, "sleep result high");
      rdChk(acs_pkg::OFF_RESL, 32'hC3, "sleep result low");
      rdChk(acs_pkg::OFF_STATUS, 32'h1, "sleep done");
      bus(1'b1, acs_pkg::OFF_MASK, 32'h0);
      start(10'h06C, 2'h3);
      sleepReq <= 1'b1;
      waitCyc(2, n);
      check("ran to end", 32'(n > 20), 32'h1);
      rdChk(acs_pkg::OFF_CTRL, 32'hD, "enable kept after done");
      rdChk(acs_pkg::OFF_RESL, 32'h6C, "masked sleep result");
      check("irq masked", {31'h0, irq}, 32'h0);
      check("wake count", 32'(wakeCount), 32'h1);
      sleepReq <= 1'b0;
      repeat (3) @(posedge core_clk);
      start(10'h3C3, 2'h0);
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'b1;
      @(posedge core_clk);
      #1 check("sampleHold in reset", {31'h0, sampleHold}, 32'h0);
      @(posedge core_clk);
      sys_rst <= 1'b0;
      resetChk();
      endSim();
   end
endmodule : tb_top
